/* File: verilog/uoam_params.svh */
// uoam_params.svh: constants of the connectivity-check message link.
// assumes a single 200 MHz packet-processing clock for both ends.
`ifndef UOAM_PARAMS_SVH
`define UOAM_PARAMS_SVH

// field widths
`define UOAM_BID_W       16
`define UOAM_HDR_W       32
`define UOAM_TS_W        32
`define UOAM_TBL_N       4
`define UOAM_TBL_IW      2

// message type and code encodings
`define UOAM_TYPE_QUERY  8'h00
`define UOAM_TYPE_REPLY  8'h08
`define UOAM_CODE_VALID  8'h00
`define UOAM_CODE_NOVAL  8'h01
`define UOAM_CODE_ACK    8'h00
`define UOAM_CODE_BAD    8'h01

// message length in bytes, without and with the three timestamps
`define UOAM_LEN_BASE    16'h0014
`define UOAM_LEN_TS      16'h0020

// service-specific field layout for circuit-emulation cell payloads
`define UOAM_SSI_SLOT_LO 16
`define UOAM_SSI_UNIT_LO 24

// timestamp resolution
`define UOAM_CLK_PERIOD_NS  5
`define UOAM_RES_FINE_NS    1000
`define UOAM_RES_COARSE_NS  100000
`define UOAM_PRE_W          15

// reply wait on the querying end, in clock cycles
`define UOAM_WAIT_CYC    16'h0FFF

`endif

/* File: verilog/uoam_pkg.sv */
// uoam_pkg.sv: message layout shared by both ends of the link.
// assumes uoam_params.svh is on the include path.
`include "uoam_params.svh"

package uoam_pkg;

  // one whole connectivity message, moved across the link in one cycle
  typedef struct packed {
    logic [`UOAM_HDR_W-1:0] psn_hdr;   // data-path header layers, opaque
    logic [`UOAM_BID_W-1:0] bid;       // oam bundle identifier
    logic [2:0]             lrm;       // local fail, remote fail, modifier
    logic [15:0]            len;
    logic [15:0]            seq;
    logic [7:0]             mtype;
    logic [7:0]             mcode;
    logic [31:0]            ssi;
    logic [`UOAM_BID_W-1:0] src_bid;
    logic [`UOAM_BID_W-1:0] dst_bid;
    logic                   ts_on;     // timestamps present
    logic                   ts_fine;   // 1 us when set, else 100 us
    logic [`UOAM_TS_W-1:0]  ts_src_tx;
    logic [`UOAM_TS_W-1:0]  ts_dst_rx;
    logic [`UOAM_TS_W-1:0]  ts_dst_tx;
  } uoam_msg_s;

  typedef logic [`UOAM_TBL_N-1:0][`UOAM_BID_W-1:0] uoam_tbl_t;

endpackage

/* File: verilog/uoam_if.sv */
// uoam_if.sv: the packet-network link between querier and responder.
// assumes both ends share one clock; each message is a one-cycle strobe.
`timescale 1ns/1ps
`default_nettype none

interface uoam_if;
  logic                q_valid;
  uoam_pkg::uoam_msg_s q_msg;
  logic                r_valid;
  uoam_pkg::uoam_msg_s r_msg;

  modport querier   (output q_valid, output q_msg,
                     input  r_valid, input  r_msg);
  modport responder (input  q_valid, input  q_msg,
                     output r_valid, output r_msg);
endinterface

`default_nettype wire

/* File: verilog/uoam_responder.sv */
// uoam_responder.sv: answering end of the connectivity check.
// assumes the querier shares clk; link strobes need no synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "uoam_params.svh"

// Function
// - oam packets use identifiers from lookup table
// - reuse data header layers, only identifier differs
// - copy current failure and modifier flags
// - length field holds message bytes
// - own sequence; query increments, reply copies
// - type 0 query, 8 reply
// - query code 0 validate, 1 not
// - reply code 0 ack, 1 mismatch
// - unused service field sent as zeros
// - bits 16-23 carry timeslot count
// - bits 24-31 carry segmentation units per packet
// - source and destination identifiers per direction
// - timestamps only when measuring, two resolutions
// - querier stamps transmit, responder receive and transmit
module uoam_responder #(
  parameter int unsigned COARSE_CYC =
    `UOAM_RES_COARSE_NS / `UOAM_CLK_PERIOD_NS
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  uoam_if.responder                   link,
  input  wire uoam_pkg::uoam_tbl_t    oam_id_tbl,
  input  wire logic [`UOAM_TBL_IW-1:0] oam_id_sel,
  input  wire logic [`UOAM_HDR_W-1:0] psn_hdr,
  input  wire logic [2:0]             lrm,
  input  wire logic [`UOAM_BID_W-1:0] tx_bid,
  input  wire logic [`UOAM_BID_W-1:0] rx_bid,
  input  wire logic                   aal1_mode,
  input  wire logic                   cfg_exchange,
  input  wire logic [7:0]             slots,
  input  wire logic [7:0]             units,
  input  wire logic                   ts_enable,
  input  wire logic                   ts_fine,
  output logic                        query_seen,
  output logic                        mismatch,
  output logic                        bad_id,
  output logic [15:0]                 query_count
);

  localparam logic [`UOAM_PRE_W-1:0] FINE_LAST =
    `UOAM_PRE_W'(`UOAM_RES_FINE_NS / `UOAM_CLK_PERIOD_NS - 1);
  localparam logic [`UOAM_PRE_W-1:0] COARSE_LAST =
    `UOAM_PRE_W'(COARSE_CYC - 1);

  typedef struct packed {
    logic [`UOAM_PRE_W-1:0] pre;
    logic [`UOAM_TS_W-1:0]  ts;
    logic                   r_valid;
    uoam_pkg::uoam_msg_s    r_msg;
    logic                   seen;
    logic                   mism;
    logic                   bad;
    logic [15:0]            count;
  } uoam_resp_s;

  uoam_resp_s st;
  uoam_resp_s next_st;
  logic [`UOAM_TBL_N-1:0] id_hit;
  logic [`UOAM_PRE_W-1:0] pre_last;
  logic                   differs;
  logic [31:0]            own_ssi;

  // identifier lookup, one comparator per table entry
  genvar gi;
  generate
    for (gi = 0; gi < `UOAM_TBL_N; gi++) begin : g_hit
      assign id_hit[gi] = (link.q_msg.bid == oam_id_tbl[gi]);
    end
  endgenerate

  // local service description, zero when not exchanging configuration
  always_comb begin
    own_ssi = 32'h0000_0000;
    if (cfg_exchange && aal1_mode) begin
      own_ssi[`UOAM_SSI_SLOT_LO +: 8] = slots;
      own_ssi[`UOAM_SSI_UNIT_LO +: 8] = units;
    end
  end

  // configuration check: the querier's send direction is our receive one
  always_comb begin
    differs = (link.q_msg.src_bid != rx_bid)
           || (link.q_msg.dst_bid != tx_bid);
    // a zero service field means the querier shares no configuration
    if (aal1_mode && (link.q_msg.ssi != 32'h0000_0000)) begin
      differs = differs
        || (link.q_msg.ssi[`UOAM_SSI_SLOT_LO +: 8] != slots)
        || (link.q_msg.ssi[`UOAM_SSI_UNIT_LO +: 8] != units);
    end
  end

  assign pre_last = ts_fine ? FINE_LAST : COARSE_LAST;

  // timestamp clock, answer builder and counters
  always_comb begin
    next_st         = st;
    next_st.r_valid = 1'b0;
    next_st.seen    = 1'b0;
    next_st.mism    = 1'b0;
    next_st.bad     = 1'b0;
    // resolution change keeps the prescaler count; any count at or past the new limit wraps to zero and ticks the time
    if (st.pre >= pre_last) begin
      next_st.pre = '0;
      next_st.ts  = st.ts + `UOAM_TS_W'(1);
    end else begin
      next_st.pre = st.pre + `UOAM_PRE_W'(1);
    end
    // answer stamps are held one cycle later, when the reply leaves
    if (st.r_valid && st.r_msg.ts_on) begin
      next_st.r_msg.ts_dst_tx = st.ts;
    end
    if (link.q_valid && (link.q_msg.mtype == `UOAM_TYPE_QUERY)) begin
      if (id_hit == '0) begin
        next_st.bad = 1'b1;
      end else begin
        next_st.seen    = 1'b1;
        next_st.count   = st.count + 16'h0001;
        next_st.r_valid = 1'b1;
        next_st.r_msg.psn_hdr = psn_hdr;
        next_st.r_msg.bid     = oam_id_tbl[oam_id_sel];
        next_st.r_msg.lrm     = lrm;
        next_st.r_msg.seq     = link.q_msg.seq;
        next_st.r_msg.mtype   = `UOAM_TYPE_REPLY;
        next_st.r_msg.ssi     = own_ssi;
        next_st.r_msg.src_bid = tx_bid;
        next_st.r_msg.dst_bid = rx_bid;
        // only a validating query is checked against our configuration
        if ((link.q_msg.mcode == `UOAM_CODE_VALID) && differs) begin
          next_st.r_msg.mcode = `UOAM_CODE_BAD;
          next_st.mism        = 1'b1;
        end else begin
          next_st.r_msg.mcode = `UOAM_CODE_ACK;
        end
        // measurement follows the query so both ends agree on the layout
        next_st.r_msg.ts_on   = link.q_msg.ts_on & ts_enable;
        next_st.r_msg.ts_fine = link.q_msg.ts_fine;
        if (link.q_msg.ts_on && ts_enable) begin
          next_st.r_msg.len       = `UOAM_LEN_TS;
          next_st.r_msg.ts_src_tx = link.q_msg.ts_src_tx;
          next_st.r_msg.ts_dst_rx = st.ts;
          next_st.r_msg.ts_dst_tx = next_st.ts;
        end else begin
          next_st.r_msg.len       = `UOAM_LEN_BASE;
          next_st.r_msg.ts_src_tx = '0;
          next_st.r_msg.ts_dst_rx = '0;
          next_st.r_msg.ts_dst_tx = '0;
        end
      end
    end
  end

  // the whole state is one register
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.r_valid = st.r_valid;
  assign link.r_msg   = st.r_msg;
  assign query_seen   = st.seen;
  assign mismatch     = st.mism;
  assign bad_id       = st.bad;
  assign query_count  = st.count;

endmodule // uoam_responder

`default_nettype wire

/* File: verilog/uoam_querier.sv */
// uoam_querier.sv: originating end of the connectivity check.
// assumes the responder shares clk; link strobes need no synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "uoam_params.svh"

module uoam_querier #(
  parameter int unsigned COARSE_CYC =
    `UOAM_RES_COARSE_NS / `UOAM_CLK_PERIOD_NS
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  uoam_if.querier                      link,
  input  wire logic                    send,
  input  wire logic                    validate,
  input  wire uoam_pkg::uoam_tbl_t     oam_id_tbl,
  input  wire logic [`UOAM_TBL_IW-1:0] oam_id_sel,
  input  wire logic [`UOAM_HDR_W-1:0]  psn_hdr,
  input  wire logic [2:0]              lrm,
  input  wire logic [`UOAM_BID_W-1:0]  tx_bid,
  input  wire logic [`UOAM_BID_W-1:0]  rx_bid,
  input  wire logic                    aal1_mode,
  input  wire logic                    cfg_exchange,
  input  wire logic [7:0]              slots,
  input  wire logic [7:0]              units,
  input  wire logic                    ts_enable,
  input  wire logic                    ts_fine,
  output logic                         busy,
  output logic                         reply_done,
  output logic                         reply_ok,
  output logic                         timeout,
  output logic [15:0]                  reply_seq,
  output logic [`UOAM_TS_W-1:0]        reply_rx_ts,
  output logic [`UOAM_TS_W-1:0]        reply_tx_ts
);

  localparam logic [`UOAM_PRE_W-1:0] FINE_LAST =
    `UOAM_PRE_W'(`UOAM_RES_FINE_NS / `UOAM_CLK_PERIOD_NS - 1);
  localparam logic [`UOAM_PRE_W-1:0] COARSE_LAST =
    `UOAM_PRE_W'(COARSE_CYC - 1);

  typedef enum logic {Q_IDLE = 1'b0, Q_WAIT = 1'b1} uoam_qstate_e;

  typedef struct packed {
    uoam_qstate_e           fsm;
    logic [`UOAM_PRE_W-1:0] pre;
    logic [`UOAM_TS_W-1:0]  ts;
    logic [15:0]            wait_cnt;
    logic                   q_valid;
    uoam_pkg::uoam_msg_s    q_msg;
    logic                   done;
    logic                   ok;
    logic                   tmo;
    logic [15:0]            rseq;
    logic [`UOAM_TS_W-1:0]  rrx;
    logic [`UOAM_TS_W-1:0]  rtx;
  } uoam_qry_s;

  uoam_qry_s st;
  uoam_qry_s next_st;
  logic [`UOAM_TBL_N-1:0] id_hit;
  logic [`UOAM_PRE_W-1:0] pre_last;

  genvar gi;
  generate
    for (gi = 0; gi < `UOAM_TBL_N; gi++) begin : g_hit
      assign id_hit[gi] = (link.r_msg.bid == oam_id_tbl[gi]);
    end
  endgenerate

  assign pre_last = ts_fine ? FINE_LAST : COARSE_LAST;

  // query builder, reply matcher and local time
  always_comb begin
    next_st         = st;
    next_st.q_valid = 1'b0;
    next_st.done    = 1'b0;
    next_st.tmo     = 1'b0;
    if (st.pre >= pre_last) begin
      next_st.pre = '0;
      next_st.ts  = st.ts + `UOAM_TS_W'(1);
    end else begin
      next_st.pre = st.pre + `UOAM_PRE_W'(1);
    end
    unique case (st.fsm)
      Q_IDLE: begin
        // a send while a query is outstanding is ignored
        if (send) begin
          next_st.fsm      = Q_WAIT;
          next_st.wait_cnt = '0;
          next_st.q_valid  = 1'b1;
          next_st.q_msg    = '0;
          next_st.q_msg.psn_hdr = psn_hdr;
          next_st.q_msg.bid     = oam_id_tbl[oam_id_sel];
          next_st.q_msg.lrm     = lrm;
          next_st.q_msg.seq     = st.q_msg.seq + 16'h0001;
          next_st.q_msg.mtype   = `UOAM_TYPE_QUERY;
          next_st.q_msg.mcode   = validate ? `UOAM_CODE_VALID
                                           : `UOAM_CODE_NOVAL;
          next_st.q_msg.src_bid = tx_bid;
          next_st.q_msg.dst_bid = rx_bid;
          if (cfg_exchange && aal1_mode) begin
            next_st.q_msg.ssi[`UOAM_SSI_SLOT_LO +: 8] = slots;
            next_st.q_msg.ssi[`UOAM_SSI_UNIT_LO +: 8] = units;
          end
          next_st.q_msg.ts_on   = ts_enable;
          next_st.q_msg.ts_fine = ts_fine;
          next_st.q_msg.len     = ts_enable ? `UOAM_LEN_TS
                                            : `UOAM_LEN_BASE;
          // the stamp is the time at which the strobe leaves
          if (ts_enable) begin
            next_st.q_msg.ts_src_tx = next_st.ts;
          end
        end
      end
      Q_WAIT: begin
        next_st.wait_cnt = st.wait_cnt + 16'h0001;
        if (link.r_valid && (id_hit != '0)
            && (link.r_msg.mtype == `UOAM_TYPE_REPLY)
            && (link.r_msg.seq == st.q_msg.seq)) begin
          next_st.fsm  = Q_IDLE;
          next_st.done = 1'b1;
          next_st.ok   = (link.r_msg.mcode == `UOAM_CODE_ACK);
          next_st.rseq = link.r_msg.seq;
          next_st.rrx  = link.r_msg.ts_dst_rx;
          next_st.rtx  = link.r_msg.ts_dst_tx;
        end else if (st.wait_cnt == `UOAM_WAIT_CYC) begin
          // a lost reply must not hang the checker
          next_st.fsm = Q_IDLE;
          next_st.tmo = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.q_valid = st.q_valid;
  assign link.q_msg   = st.q_msg;
  assign busy         = (st.fsm == Q_WAIT);
  assign reply_done   = st.done;
  assign reply_ok     = st.ok;
  assign timeout      = st.tmo;
  assign reply_seq    = st.rseq;
  assign reply_rx_ts  = st.rrx;
  assign reply_tx_ts  = st.rtx;

endmodule // uoam_querier

`default_nettype wire

/* File: test/uoam_asserts.sv */
// uoam_asserts.sv: checks on the link between querier and responder.
// assumes one clock, sync active-high reset, link signals as inputs.
`timescale 1ns/1ps
`default_nettype none
`include "uoam_params.svh"

module uoam_asserts (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                q_valid,
  input wire uoam_pkg::uoam_msg_s q_msg,
  input wire logic                r_valid,
  input wire uoam_pkg::uoam_msg_s r_msg
);
  logic [15:0] last_seq;

  // last query number, kept so the step is seen across long gaps
  always_ff @(posedge clk) begin
    if (rst)
      last_seq <= 16'h0000;
    else if (q_valid)
      last_seq <= q_msg.seq;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reply_cause: assert property (
    r_valid |-> $past(q_valid) && $past(q_msg.mtype) == `UOAM_TYPE_QUERY)
    else $error("reply without a query");
  chk_reply_seq_copy: assert property (
    r_valid |-> r_msg.seq == $past(q_msg.seq))
    else $error("reply number differs from query");
  chk_seq_step: assert property (
    q_valid |-> q_msg.seq == last_seq + 16'h0001)
    else $error("query number not stepped by one");
  chk_query_type: assert property (
    q_valid |-> q_msg.mtype == `UOAM_TYPE_QUERY && q_msg.mcode <= 8'h01)
    else $error("bad query type or code");
  chk_reply_type: assert property (
    r_valid |-> r_msg.mtype == `UOAM_TYPE_REPLY && r_msg.mcode <= 8'h01)
    else $error("bad reply type or code");
  chk_query_len: assert property (
    q_valid |-> q_msg.len == (q_msg.ts_on ? `UOAM_LEN_TS : `UOAM_LEN_BASE))
    else $error("query length wrong");
  chk_reply_len: assert property (
    r_valid |-> r_msg.len == (r_msg.ts_on ? `UOAM_LEN_TS : `UOAM_LEN_BASE))
    else $error("reply length wrong");
  chk_ts_absent: assert property (
    r_valid && !r_msg.ts_on |-> r_msg.ts_dst_rx == 32'h0 &&
      r_msg.ts_dst_tx == 32'h0)
    else $error("timestamps present while off");
  chk_ts_asked: assert property (
    r_valid && r_msg.ts_on |-> $past(q_msg.ts_on))
    else $error("reply stamped for unstamped query");
  chk_ts_order: assert property (
    r_valid && r_msg.ts_on |-> r_msg.ts_dst_tx >= r_msg.ts_dst_rx)
    else $error("reply sent before query received");

  cov_bad_code: cover property (r_valid && r_msg.mcode == `UOAM_CODE_BAD);
  cov_stamped: cover property (r_valid && r_msg.ts_on);
  cov_noval: cover property (q_valid && q_msg.mcode == `UOAM_CODE_NOVAL);
endmodule // uoam_asserts

`default_nettype wire

/* File: test/udp_oam_packet_format_tb.sv */
// udp_oam_packet_format_tb.sv: querier and responder joined by one link.
// assumes 200 MHz clock, sync reset, short coarse tick for simulation.
`timescale 1ns/1ps
`default_nettype none

module udp_oam_packet_format_tb;
  logic                clk = 0, rst = 1, send = 0, validate = 1;
  logic                cfgx = 1, tse = 0, tsf = 0;
  logic [1:0]          qsel = 2'h0, rsel = 2'h1;
  logic [31:0]         hdr = 32'hC0DE0001;
  logic [2:0]          flg = 3'h5;
  logic [15:0]         qtx = 16'h0101, qrx = 16'h0202;
  logic                aal = 1;
  logic [7:0]          slt = 8'h18, unt = 8'h08;
  logic [15:0]         ra = 16'h0101, rseq, qcnt;
  logic [31:0]         rrx, rtx;
  logic                busy, rdone, rok, tmo, qseen, mis, bad;
  uoam_pkg::uoam_tbl_t qtbl = {16'h0D04, 16'h0C03, 16'h0B02, 16'h0A01};
  uoam_pkg::uoam_tbl_t rtbl = {16'h0E05, 16'h0C03, 16'h0B02, 16'h0A01};
  int                  n_errors = 0, cmp_count = 0, cyc = 0;
  int                  n_seen = 0, n_mis = 0, n_bad = 0;

  uoam_if lk ();

  uoam_querier #(.COARSE_CYC(50)) u_uoam_querier (
    .clk(clk), .rst(rst), .link(lk), .send(send), .validate(validate),
    .oam_id_tbl(qtbl), .oam_id_sel(qsel), .psn_hdr(hdr),
    .lrm(flg), .tx_bid(qtx), .rx_bid(qrx), .aal1_mode(aal),
    .cfg_exchange(cfgx), .slots(slt), .units(unt), .ts_enable(tse),
    .ts_fine(tsf), .busy(busy), .reply_done(rdone), .reply_ok(rok),
    .timeout(tmo), .reply_seq(rseq), .reply_rx_ts(rrx), .reply_tx_ts(rtx));

  // the reply identifier is taken from slot 1 so it differs from queries
  uoam_responder #(.COARSE_CYC(50)) u_uoam_responder (
    .clk(clk), .rst(rst), .link(lk), .oam_id_tbl(rtbl), .oam_id_sel(rsel),
    .psn_hdr(hdr), .lrm(flg), .tx_bid(qrx), .rx_bid(ra),
    .aal1_mode(aal), .cfg_exchange(cfgx), .slots(slt), .units(unt),
    .ts_enable(tse), .ts_fine(tsf), .query_seen(qseen), .mismatch(mis),
    .bad_id(bad), .query_count(qcnt));

  uoam_asserts u_uoam_asserts (
    .clk(clk), .rst(rst), .q_valid(lk.q_valid), .q_msg(lk.q_msg),
    .r_valid(lk.r_valid), .r_msg(lk.r_msg));

  always #2.5 clk = ~clk;

  // pulses are counted here since a one-cycle strobe is easy to miss
  always @(posedge clk) begin
    cyc++;
    if (qseen === 1'b1) n_seen++;
    if (mis === 1'b1) n_mis++;
    if (bad === 1'b1) n_bad++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  // one query; waits for reply or timeout with a bound past 0x1000 cycles
  task automatic query(input logic v, input logic done, input logic ok,
                       input logic [15:0] sq);
    int i;
    @(posedge clk);
    #1 validate = v;
    send = 1;
    @(posedge clk);
    #1 send = 0;
    for (i = 0; i < 5000; i++) begin
      if (rdone === 1'b1 || tmo === 1'b1) break;
      @(posedge clk);
      #1;
    end
    chk(rdone, done, "reply done");
    chk(tmo, !done, "timeout");
    chk(busy, 0, "busy after end");
    chk(lk.q_msg.seq, sq, "query number");
    if (done) begin
      chk(rok, ok, "reply ok");
      chk(rseq, sq, "reply number");
    end
  endtask

  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    query(1, 1, 1, 16'h0001);
    chk(lk.q_msg.bid, 16'h0A01, "query id");
    chk(lk.r_msg.bid, 16'h0B02, "reply id");
    chk(lk.q_msg.psn_hdr, 32'hC0DE0001, "query header");
    chk(lk.r_msg.psn_hdr, 32'hC0DE0001, "reply header");
    chk(lk.q_msg.lrm, 3'h5, "query flags");
    chk(lk.r_msg.lrm, 3'h5, "reply flags");
    chk(lk.r_msg.len, 16'h0014, "reply length");
    chk(lk.r_msg.mtype, 8'h08, "reply type");
    chk(lk.q_msg.mcode, 8'h00, "validate code");
    chk(lk.q_msg.ssi, 32'h08180000, "query service");
    chk(lk.r_msg.ssi, 32'h08180000, "reply service");
    chk(lk.q_msg.src_bid, 16'h0101, "query source");
    chk(lk.q_msg.dst_bid, 16'h0202, "query dest");
    chk(lk.r_msg.src_bid, 16'h0202, "reply source");
    // responder expects another source id: validation must fail
    ra = 16'h0303;
    query(1, 1, 0, 16'h0002);
    chk(lk.r_msg.mcode, 8'h01, "mismatch code");
    query(0, 1, 1, 16'h0003);
    chk(lk.q_msg.mcode, 8'h01, "no validate code");
    ra = 16'h0101;
    cfgx = 0;
    tse = 1;
    tsf = 1;
    query(1, 1, 1, 16'h0004);
    chk(lk.r_msg.len, 16'h0020, "stamped length");
    chk(lk.q_msg.ssi, 32'h0, "unused service");
    chk(lk.r_msg.ssi, 32'h0, "unused reply service");
    chk(lk.r_msg.ts_fine, 1'b1, "fine resolution");
    chk(rtx >= rrx, 1'b1, "stamp order");
    tsf = 0;
    query(1, 1, 1, 16'h0005);
    chk(lk.r_msg.ts_fine, 1'b0, "coarse resolution");
    // slot 3 of the querier is unknown to the responder: no reply
    qsel = 2'h3;
    query(1, 0, 0, 16'h0006);
    qsel = 2'h0;
    query(1, 1, 1, 16'h0007);
    chk(qcnt, 16'h0006, "accepted count");
    chk(n_seen, 6, "seen pulses");
    chk(n_mis, 1, "mismatch pulses");
    chk(n_bad, 1, "bad id pulses");
    complete_run();
  end
endmodule // udp_oam_packet_format_tb

`default_nettype wire
